// *** verilog/gpp_pkg.sv ***
// Package for the port F/G/H general-purpose I/O block.
// Assumes one clock domain and a plain strobe register port.
package gpp_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_PORT_F_DIRECTION = 4'h0;
  localparam logic [3:0] ADDR_PORT_F_PINS = 4'h1;
  localparam logic [3:0] ADDR_PORT_F_LATCH = 4'h2;
  localparam logic [3:0] ADDR_PORT_G_DIRECTION = 4'h3;
  localparam logic [3:0] ADDR_PORT_G_PINS = 4'h4;
  localparam logic [3:0] ADDR_PORT_G_LATCH = 4'h5;
  localparam logic [3:0] ADDR_PORT_H_DIRECTION = 4'h6;
  localparam logic [3:0] ADDR_PORT_H_PINS = 4'h7;
  localparam logic [3:0] ADDR_PORT_H_LATCH = 4'h8;
  localparam logic [3:0] ADDR_ANALOG_PIN_CONFIG = 4'h9;
  localparam logic [3:0] ADDR_COMPARATOR_CONTROL = 4'ha;
  localparam logic [3:0] ADDR_COMPARATOR_REFERENCE_CONTROL = 4'hb;
  localparam logic [3:0] ADDR_EXTERNAL_BUS_CONTROL = 4'hc;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIRECTION_ALL_IN = 8'hff;
  localparam logic [4:0] RST_PORT_G_DIRECTION = 5'h1f;
  localparam logic [7:0] RST_PORT_F_LATCH = 8'h00;
  localparam logic [7:0] RST_LATCH_OTHER = 8'h00;
  localparam logic [7:0] RST_ANALOG_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_COMPARATOR_CONTROL = 8'h00;
  localparam logic [7:0] RST_COMPARATOR_REFERENCE_CONTROL = 8'h00;
  localparam logic [7:0] RST_EXTERNAL_BUS_CONTROL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_BUS_DISABLE = 7;
  localparam int BIT_REF_OUTPUT_ENABLE = 6;
  localparam int BIT_SLAVE_SELECT_ENABLE = 0;
  localparam logic [3:0] PCFG_ALL_DIGITAL = 4'hf;
  localparam logic [2:0] CMP_OFF = 3'h7;
  localparam logic [2:0] CMP_OUTPUTS_ON_PINS = 3'h5;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpp_bus_req_type;

  typedef struct packed {
    logic comparator_one_output;
    logic comparator_two_output;
    logic comparator_reference_output;
    logic second_serial_transmit_clock;
    logic second_serial_transmit_clock_en;
    logic second_serial_receive_data;
    logic second_serial_receive_data_en;
    logic [2:0] ccp_out;
    logic [2:0] ccp_out_en;
    logic [3:0] bus_address_high;
    logic bus_address_en;
  } gpp_periph_type;

endpackage : gpp_pkg

// *** verilog/gpp_pin_bit.sv ***
// One port pin: direction, peripheral override and pin drive.
// Assumes the pin is resolved outside from output and output enable.
`timescale 1ns/1ns
`default_nettype none
module gpp_pin_bit
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Port state
  input wire logic direction,
  input wire logic latch,
  // Peripheral override
  input wire logic ovr_out,
  input wire logic ovr_in,
  input wire logic ovr_data,
  // Pin
  output logic pin_out,
  output logic pin_oe_n
);

  logic drive;
  logic value;

  // A forced input wins over a forced output, then the direction bit.
  assign drive = ~ovr_in & (ovr_out | ~direction);
  assign value = ovr_out ? ovr_data : latch;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_oe_n <= 1'b1;
      pin_out <= 1'b0;
    end
    else
    begin
      pin_oe_n <= ~drive;
      pin_out <= value;
    end
  end

endmodule : gpp_pin_bit
`default_nettype wire

// *** verilog/gpp_ports.sv ***
// General-purpose I/O for ports F, G and H with peripheral pin sharing.
// Assumes synchronous pins, a plain strobe register port and one clock.
//
// Function
// - Direction bit one tri-states the pin driver, pin is input.
// - Direction bit zero drives the pin from the output latch.
// - Read-modify-write of the latch register uses latch, not pin level.
// - Pin register reads pin levels; writes update the output latch.
// - Latch register reads and writes the stored output latch.
// - Port G is six bits: five bidirectional, bit 5 input only.
// - An enabled peripheral may force its pin to output or input.
// - Forced direction is never written into the direction register.
// - Power-on reset sets port G direction bits to ones.
// - Port G bit 5 is master clear when enable is one.
// - Bit 5 reads as digital input only when master clear disabled.
// - Port H 7:4 share analog 15:12; 3:0 carry address 19:16.
// - Port H 7:4 default analog, 3:0 default address lines.
// - External bus control selects port H 3:0 as I/O or bus.
// - After power-on reset, analog port H pins read zero.
// - Port F bit 7 may be serial slave-select input.
// - Port F bits 1,2 output comparators 2,1; bit 5 reference.
// - Port G 1,2 serve second serial; 0,3,4 serve capture channels.
// - Power-on reset clears port F latch, sets its direction to ones.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module gpp_ports
#(
  parameter int PORT_F_WIDTH = 8,
  parameter int PORT_G_WIDTH = 5,
  parameter int PORT_H_WIDTH = 8
)
(
  // Clock and resets
  input wire logic mclk,
  input wire logic resetn,
  input wire logic soft_reset,
  // Configuration
  input wire logic master_clear_enable,
  // Register port
  input wire gpp_pkg::gpp_bus_req_type bus_req,
  output logic [7:0] rdata,
  // Peripheral side
  input wire gpp_pkg::gpp_periph_type periph,
  output logic slave_select_in,
  output logic second_serial_receive_in,
  output logic master_clear_input,
  // Port F pins
  input wire logic [PORT_F_WIDTH-1:0] port_f_in,
  output logic [PORT_F_WIDTH-1:0] port_f_out,
  output logic [PORT_F_WIDTH-1:0] port_f_oe_n,
  // Port G pins
  input wire logic [PORT_G_WIDTH:0] port_g_in,
  output logic [PORT_G_WIDTH-1:0] port_g_out,
  output logic [PORT_G_WIDTH-1:0] port_g_oe_n,
  // Port H pins
  input wire logic [PORT_H_WIDTH-1:0] port_h_in,
  output logic [PORT_H_WIDTH-1:0] port_h_out,
  output logic [PORT_H_WIDTH-1:0] port_h_oe_n
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [PORT_F_WIDTH-1:0] port_f_direction_q;
  logic [PORT_F_WIDTH-1:0] port_f_latch_q;
  logic [PORT_G_WIDTH-1:0] port_g_direction_q;
  logic [PORT_G_WIDTH-1:0] port_g_latch_q;
  logic [PORT_H_WIDTH-1:0] port_h_direction_q;
  logic [PORT_H_WIDTH-1:0] port_h_latch_q;
  logic [7:0] analog_pin_config_q;
  logic [7:0] comparator_control_q;
  logic [7:0] comparator_reference_control_q;
  logic [7:0] external_bus_control_q;
  logic [7:0] rdata_q;
  logic slave_select_q;
  logic serial_rx_q;
  logic master_clear_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr_f_dir = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_PORT_F_DIRECTION);
  wire logic wr_f_lat = bus_req.wr & ((bus_req.addr == gpp_pkg::ADDR_PORT_F_PINS)
                                    | (bus_req.addr == gpp_pkg::ADDR_PORT_F_LATCH));
  wire logic wr_g_dir = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_PORT_G_DIRECTION);
  wire logic wr_g_lat = bus_req.wr & ((bus_req.addr == gpp_pkg::ADDR_PORT_G_PINS)
                                    | (bus_req.addr == gpp_pkg::ADDR_PORT_G_LATCH));
  wire logic wr_h_dir = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_PORT_H_DIRECTION);
  wire logic wr_h_lat = bus_req.wr & ((bus_req.addr == gpp_pkg::ADDR_PORT_H_PINS)
                                    | (bus_req.addr == gpp_pkg::ADDR_PORT_H_LATCH));
  wire logic wr_adc = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_ANALOG_PIN_CONFIG);
  wire logic wr_cmp = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_COMPARATOR_CONTROL);
  wire logic wr_ref = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_COMPARATOR_REFERENCE_CONTROL);
  wire logic wr_ebc = bus_req.wr & (bus_req.addr == gpp_pkg::ADDR_EXTERNAL_BUS_CONTROL);

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  // Port H upper nibble is digital only when the analog config selects it
  wire logic h_upper_digital = (analog_pin_config_q[3:0] == gpp_pkg::PCFG_ALL_DIGITAL);
  wire logic h_bus_on = ~external_bus_control_q[gpp_pkg::BIT_BUS_DISABLE];
  wire logic f_analog = (analog_pin_config_q[3:0] != gpp_pkg::PCFG_ALL_DIGITAL);
  wire logic cmp_pins = (comparator_control_q[2:0] == gpp_pkg::CMP_OUTPUTS_ON_PINS);
  wire logic ref_pin = comparator_reference_control_q[gpp_pkg::BIT_REF_OUTPUT_ENABLE];
  wire logic ss_on = comparator_reference_control_q[gpp_pkg::BIT_SLAVE_SELECT_ENABLE];

  // Port F override vectors
  wire logic [PORT_F_WIDTH-1:0] f_ovr_out = {2'b00, ref_pin, 2'b00, cmp_pins, cmp_pins, 1'b0};
  wire logic [PORT_F_WIDTH-1:0] f_ovr_in = {ss_on, {(PORT_F_WIDTH-1){1'b0}}};
  wire logic [PORT_F_WIDTH-1:0] f_ovr_data = {2'b00, periph.comparator_reference_output, 2'b00,
                                             periph.comparator_one_output, periph.comparator_two_output, 1'b0};

  // Port G override vectors
  wire logic [PORT_G_WIDTH-1:0] g_ovr_out = {periph.ccp_out_en[2], periph.ccp_out_en[1],
                                             periph.second_serial_receive_data_en,
                                             periph.second_serial_transmit_clock_en,
                                             periph.ccp_out_en[0]};
  wire logic [PORT_G_WIDTH-1:0] g_ovr_data = {periph.ccp_out[2], periph.ccp_out[1],
                                              periph.second_serial_receive_data,
                                              periph.second_serial_transmit_clock,
                                              periph.ccp_out[0]};

  // Port H override vectors
  wire logic [PORT_H_WIDTH-1:0] h_ovr_out = {4'h0, {4{h_bus_on}}};
  wire logic [PORT_H_WIDTH-1:0] h_ovr_in = {{4{~h_upper_digital}}, 4'h0};
  wire logic [PORT_H_WIDTH-1:0] h_ovr_data = {4'h0, periph.bus_address_high};

  // ----------------------------------------------------------------
  // Pin read values
  // ----------------------------------------------------------------
  // Analog pins read as zero in the digital path
  wire logic [7:0] f_read = f_analog ? {port_f_in[7], 7'h00} : port_f_in;
  wire logic [7:0] h_read = {(h_upper_digital ? port_h_in[7:4] : 4'h0), port_h_in[3:0]};
  wire logic g5_read = ~master_clear_enable & port_g_in[PORT_G_WIDTH];
  wire logic [7:0] g_read = {2'b00, g5_read, port_g_in[PORT_G_WIDTH-1:0]};

  logic [7:0] rdata_d;
  always_comb
  begin
    unique case (bus_req.addr)
      gpp_pkg::ADDR_PORT_F_DIRECTION: rdata_d = port_f_direction_q;
      gpp_pkg::ADDR_PORT_F_PINS: rdata_d = f_read;
      gpp_pkg::ADDR_PORT_F_LATCH: rdata_d = port_f_latch_q;
      gpp_pkg::ADDR_PORT_G_DIRECTION: rdata_d = {3'h0, port_g_direction_q};
      gpp_pkg::ADDR_PORT_G_PINS: rdata_d = g_read;
      gpp_pkg::ADDR_PORT_G_LATCH: rdata_d = {3'h0, port_g_latch_q};
      gpp_pkg::ADDR_PORT_H_DIRECTION: rdata_d = port_h_direction_q;
      gpp_pkg::ADDR_PORT_H_PINS: rdata_d = h_read;
      gpp_pkg::ADDR_PORT_H_LATCH: rdata_d = port_h_latch_q;
      gpp_pkg::ADDR_ANALOG_PIN_CONFIG: rdata_d = analog_pin_config_q;
      gpp_pkg::ADDR_COMPARATOR_CONTROL: rdata_d = comparator_control_q;
      gpp_pkg::ADDR_COMPARATOR_REFERENCE_CONTROL: rdata_d = comparator_reference_control_q;
      gpp_pkg::ADDR_EXTERNAL_BUS_CONTROL: rdata_d = external_bus_control_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Direction registers: reset to input on any reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_f_direction_q <= gpp_pkg::RST_DIRECTION_ALL_IN;
      port_g_direction_q <= gpp_pkg::RST_PORT_G_DIRECTION;
      port_h_direction_q <= gpp_pkg::RST_DIRECTION_ALL_IN;
    end
    else if (soft_reset)
    begin
      port_f_direction_q <= gpp_pkg::RST_DIRECTION_ALL_IN;
      port_g_direction_q <= gpp_pkg::RST_PORT_G_DIRECTION;
      port_h_direction_q <= gpp_pkg::RST_DIRECTION_ALL_IN;
    end
    else
    begin
      // Only software writes land here, never an override
      if (wr_f_dir)
        port_f_direction_q <= bus_req.wdata;
      if (wr_g_dir)
        port_g_direction_q <= bus_req.wdata[PORT_G_WIDTH-1:0];
      if (wr_h_dir)
        port_h_direction_q <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Latches and configuration: kept across soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_f_latch_q <= gpp_pkg::RST_PORT_F_LATCH;
      port_g_latch_q <= gpp_pkg::RST_LATCH_OTHER[PORT_G_WIDTH-1:0];
      port_h_latch_q <= gpp_pkg::RST_LATCH_OTHER;
      analog_pin_config_q <= gpp_pkg::RST_ANALOG_PIN_CONFIG;
      comparator_control_q <= gpp_pkg::RST_COMPARATOR_CONTROL;
      comparator_reference_control_q <= gpp_pkg::RST_COMPARATOR_REFERENCE_CONTROL;
      external_bus_control_q <= gpp_pkg::RST_EXTERNAL_BUS_CONTROL;
    end
    else if (!soft_reset)
    begin
      if (wr_f_lat)
        port_f_latch_q <= bus_req.wdata;
      if (wr_g_lat)
        port_g_latch_q <= bus_req.wdata[PORT_G_WIDTH-1:0];
      if (wr_h_lat)
        port_h_latch_q <= bus_req.wdata;
      if (wr_adc)
        analog_pin_config_q <= bus_req.wdata;
      if (wr_cmp)
        comparator_control_q <= bus_req.wdata;
      if (wr_ref)
        comparator_reference_control_q <= bus_req.wdata;
      if (wr_ebc)
        external_bus_control_q <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data and peripheral inputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= 8'h00;
      slave_select_q <= 1'b1;
      serial_rx_q <= 1'b1;
      master_clear_q <= 1'b1;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rdata_d : 8'h00;
      slave_select_q <= ss_on ? port_f_in[7] : 1'b1;
      serial_rx_q <= port_g_in[2];
      master_clear_q <= master_clear_enable ? port_g_in[PORT_G_WIDTH] : 1'b1;
    end
  end

  assign rdata = rdata_q;
  assign slave_select_in = slave_select_q;
  assign second_serial_receive_in = serial_rx_q;
  assign master_clear_input = master_clear_q;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < PORT_F_WIDTH; i++)
    begin : g_pf
      gpp_pin_bit u_bit (.mclk(mclk), .resetn(resetn), .direction(port_f_direction_q[i]),
        .latch(port_f_latch_q[i]), .ovr_out(f_ovr_out[i]), .ovr_in(f_ovr_in[i]),
        .ovr_data(f_ovr_data[i]), .pin_out(port_f_out[i]), .pin_oe_n(port_f_oe_n[i]));
    end
    for (i = 0; i < PORT_G_WIDTH; i++)
    begin : g_pg
      gpp_pin_bit u_bit (.mclk(mclk), .resetn(resetn), .direction(port_g_direction_q[i]),
        .latch(port_g_latch_q[i]), .ovr_out(g_ovr_out[i]), .ovr_in(1'b0),
        .ovr_data(g_ovr_data[i]), .pin_out(port_g_out[i]), .pin_oe_n(port_g_oe_n[i]));
    end
    for (i = 0; i < PORT_H_WIDTH; i++)
    begin : g_ph
      gpp_pin_bit u_bit (.mclk(mclk), .resetn(resetn), .direction(port_h_direction_q[i]),
        .latch(port_h_latch_q[i]), .ovr_out(h_ovr_out[i]), .ovr_in(h_ovr_in[i]),
        .ovr_data(h_ovr_data[i]), .pin_out(port_h_out[i]), .pin_oe_n(port_h_oe_n[i]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_dir_input_tristate: assert property (@(posedge mclk) disable iff (!resetn)
    (port_g_direction_q[3] && !g_ovr_out[3]) |=> port_g_oe_n[3])
    else $error("port g pin 3 driven while input");

  a_dir_output_drives: assert property (@(posedge mclk) disable iff (!resetn)
    (!port_g_direction_q[3] && !g_ovr_out[3]) |=> (!port_g_oe_n[3] && port_g_out[3] == $past(port_g_latch_q[3])))
    else $error("port g pin 3 not driven from latch");

  a_pins_write_latch: assert property (@(posedge mclk) disable iff (!resetn || soft_reset)
    (bus_req.wr && bus_req.addr == gpp_pkg::ADDR_PORT_F_PINS) |=> port_f_latch_q == $past(bus_req.wdata))
    else $error("pin register write missed latch");

  a_latch_readback: assert property (@(posedge mclk) disable iff (!resetn)
    (bus_req.rd && bus_req.addr == gpp_pkg::ADDR_PORT_H_LATCH) |=> rdata == $past(port_h_latch_q))
    else $error("latch read wrong");

  a_soft_reset_dirs: assert property (@(posedge mclk) disable iff (!resetn)
    soft_reset |=> (port_f_direction_q == 8'hff && port_g_direction_q == 5'h1f && $stable(port_f_latch_q)))
    else $error("soft reset handling wrong");

  a_override_no_store: assert property (@(posedge mclk) disable iff (!resetn)
    (!wr_g_dir && !soft_reset) |=> $stable(port_g_direction_q))
    else $error("direction changed without write");

  a_master_clear_input_bit_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (master_clear_enable && bus_req.rd && bus_req.addr == gpp_pkg::ADDR_PORT_G_PINS) |=> !rdata[5])
    else $error("bit 5 readable while master clear");

  a_bus_drives_h: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && h_bus_on) |=> (port_h_oe_n[3:0] == 4'h0 && port_h_out[3:0] == $past(periph.bus_address_high)))
    else $error("bus address not on port h");

  a_analog_reads_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (!h_upper_digital && bus_req.rd && bus_req.addr == gpp_pkg::ADDR_PORT_H_PINS) |=> rdata[7:4] == 4'h0)
    else $error("analog pins not read as zero");

endmodule : gpp_ports
`default_nettype wire

// *** test/gpp_pin_model.sv ***
// Pad model for the port F/G/H block: resolves each pad level.
// Assumes board levels come from the testbench; no pulls on pads.
`timescale 1ns/1ns
`default_nettype none
module gpp_pin_model
#(
  parameter int W = 8
)
(
  // Block side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  // Board side
  input wire logic [W-1:0] board,
  output logic [W-1:0] level
);
  // Block wins where it drives, board elsewhere
  assign level = (pin_oe_n & board) | (~pin_oe_n & pin_out);
endmodule : gpp_pin_model
`default_nettype wire

// *** test/tb_gpp_ports.sv ***
// Testbench for the port F/G/H block: registers, pins, overrides, resets.
// Assumes the design package, design modules and pad model compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_gpp_ports;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic soft_reset = 1'b0;
  logic clr_en = 1'b1;
  gpp_pkg::gpp_bus_req_type bus_req = '0;
  gpp_pkg::gpp_periph_type periph = '{bus_address_high: 4'h9, default: '0};
  logic [7:0] rdata, f_out, f_oe, f_lvl, h_out, h_oe, h_lvl, rd_v;
  logic [7:0] f_brd = 8'h3c;
  logic [7:0] h_brd = 8'hff;
  logic [4:0] g_out, g_oe, g_lvl;
  logic [5:0] g_brd = 6'h2a;
  logic ss_in, rx_in, mc_in;
  int failures = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Block and pads
  // ----------------------------------------------------------------
  gpp_ports dut
  (
    .mclk(mclk), .resetn(resetn), .soft_reset(soft_reset), .master_clear_enable(clr_en),
    .bus_req(bus_req), .rdata(rdata), .periph(periph), .slave_select_in(ss_in),
    .second_serial_receive_in(rx_in), .master_clear_input(mc_in),
    .port_f_in(f_lvl), .port_f_out(f_out), .port_f_oe_n(f_oe),
    .port_g_in({g_brd[5], g_lvl}), .port_g_out(g_out), .port_g_oe_n(g_oe),
    .port_h_in(h_lvl), .port_h_out(h_out), .port_h_oe_n(h_oe)
  );
  gpp_pin_model #(.W(8)) pads_f (.pin_out(f_out), .pin_oe_n(f_oe), .board(f_brd), .level(f_lvl));
  gpp_pin_model #(.W(5)) pads_g (.pin_out(g_out), .pin_oe_n(g_oe), .board(g_brd[4:0]), .level(g_lvl));
  gpp_pin_model #(.W(8)) pads_h (.pin_out(h_out), .pin_oe_n(h_oe), .board(h_brd), .level(h_lvl));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 rd_v = rdata;
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(gpp_pkg::ADDR_PORT_F_DIRECTION);
    chk(rd_v, 8'hff);
    rd(gpp_pkg::ADDR_PORT_F_LATCH);
    chk(rd_v, 8'h00);
    rd(gpp_pkg::ADDR_PORT_G_DIRECTION);
    chk(rd_v & 8'h1f, 8'h1f);
    chk(f_oe, 8'hff);
    chk({3'h0, g_oe}, 8'h1f);
    chk({4'h0, h_oe[3:0]}, 8'h00);
    chk({4'h0, h_out[3:0]}, 8'h09);
    rd(gpp_pkg::ADDR_PORT_H_PINS);
    chk(rd_v & 8'hf0, 8'h00);
    rd(4'hd);
    chk(rd_v, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_drive;
    wr(gpp_pkg::ADDR_ANALOG_PIN_CONFIG, 8'h0f);
    wr(gpp_pkg::ADDR_COMPARATOR_CONTROL, 8'h07);
    wr(gpp_pkg::ADDR_PORT_F_PINS, 8'h5a);
    rd(gpp_pkg::ADDR_PORT_F_LATCH);
    chk(rd_v, 8'h5a);
    rd(gpp_pkg::ADDR_PORT_F_PINS);
    chk(rd_v, 8'h3c);
    wr(gpp_pkg::ADDR_PORT_F_DIRECTION, 8'hf0);
    settle;
    chk(f_oe, 8'hf0);
    chk(f_out & 8'h0f, 8'h0a);
    rd(gpp_pkg::ADDR_PORT_F_PINS);
    chk(rd_v, 8'h3a);
    rd(gpp_pkg::ADDR_PORT_F_LATCH);
    chk(rd_v, 8'h5a);
    $display("test drive done");
  endtask : t_drive
  task automatic t_port_g;
    wr(gpp_pkg::ADDR_PORT_G_LATCH, 8'hff);
    rd(gpp_pkg::ADDR_PORT_G_LATCH);
    chk(rd_v & 8'h1f, 8'h1f);
    rd(gpp_pkg::ADDR_PORT_G_PINS);
    chk(rd_v & 8'h20, 8'h00);
    @(posedge mclk);
    clr_en <= 1'b0;
    settle;
    rd(gpp_pkg::ADDR_PORT_G_PINS);
    chk(rd_v & 8'h20, 8'h20);
    chk({7'h0, mc_in}, 8'h01);
    @(posedge mclk);
    clr_en <= 1'b1;
    g_brd <= 6'h0a;
    periph.ccp_out_en <= 3'h1;
    periph.ccp_out <= 3'h1;
    settle;
    chk({7'h0, mc_in}, 8'h00);
    chk({6'h0, g_oe[0], g_out[0]}, 8'h01);
    rd(gpp_pkg::ADDR_PORT_G_DIRECTION);
    chk(rd_v & 8'h1f, 8'h1f);
    wr(gpp_pkg::ADDR_PORT_G_DIRECTION, 8'h04);
    periph.second_serial_receive_data_en <= 1'b1;
    periph.second_serial_transmit_clock_en <= 1'b1;
    settle;
    chk({6'h0, g_oe[2:1]}, 8'h00);
    chk({6'h0, g_out[1], rx_in}, 8'h00);
    $display("test port g done");
  endtask : t_port_g
  task automatic t_periph_f;
    wr(gpp_pkg::ADDR_PORT_F_DIRECTION, 8'h00);
    wr(gpp_pkg::ADDR_PORT_F_LATCH, 8'h00);
    periph.comparator_one_output <= 1'b1;
    periph.comparator_two_output <= 1'b1;
    periph.comparator_reference_output <= 1'b1;
    f_brd <= 8'h00;
    wr(gpp_pkg::ADDR_COMPARATOR_CONTROL, 8'h05);
    wr(gpp_pkg::ADDR_COMPARATOR_REFERENCE_CONTROL, 8'h41);
    settle;
    chk(f_out & 8'h26, 8'h26);
    chk(f_oe & 8'h80, 8'h80);
    chk({7'h0, ss_in}, 8'h00);
    $display("test port f periph done");
  endtask : t_periph_f
  task automatic t_port_h;
    wr(gpp_pkg::ADDR_PORT_H_LATCH, 8'h06);
    wr(gpp_pkg::ADDR_PORT_H_DIRECTION, 8'hf0);
    settle;
    chk({4'h0, h_out[3:0]}, 8'h09);
    wr(gpp_pkg::ADDR_EXTERNAL_BUS_CONTROL, 8'h80);
    settle;
    chk({h_oe[3:0], h_out[3:0]}, 8'h06);
    $display("test port h done");
  endtask : t_port_h
  task automatic t_soft;
    @(posedge mclk);
    soft_reset <= 1'b1;
    wr(gpp_pkg::ADDR_PORT_F_LATCH, 8'hff);
    @(posedge mclk);
    soft_reset <= 1'b0;
    rd(gpp_pkg::ADDR_PORT_F_DIRECTION);
    chk(rd_v, 8'hff);
    rd(gpp_pkg::ADDR_PORT_F_LATCH);
    chk(rd_v, 8'h00);
    rd(gpp_pkg::ADDR_PORT_H_LATCH);
    chk(rd_v, 8'h06);
    $display("test soft reset done");
  endtask : t_soft
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_drive;
    t_port_g;
    t_periph_f;
    t_port_h;
    t_soft;
    wrap_up;
  end
  initial
  begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule : tb_gpp_ports
`default_nettype wire
